// File: omd_decoder.sv
`timescale 1ns/1ps
// How it works
// R1 - cpu 000000h-00FFFFh hits eight dual blocks
// R2 - dual block serves two accesses per cycle
// R3 - dual ram open to program, data, dma
// R4 - dma sees dual ram at cpu plus 10000h
// R5 - lowest 192 bytes excluded as register space
// R6 - cpu 010000h-04FFFFh hits 32 single blocks
// R7 - single block serves one access per cycle
// R8 - single ram open to all four masters
// R9 - dma/usb see single ram at plus 80000h
// R10 - software leaves last block to bootloader first
// R11 - FE0000h-FFFFFFh hits four rom blocks
// R12 - unmap bit removes rom from the map
// R13 - hardware reset clears the unmap bit
// R14 - software reset keeps the unmap bit
// R15 - rom readable from program and data buses
// R16 - rom block returns one word per cycle
// R17 - cpu space spans 16M bytes, unified
// R18 - dma moves 32 bits per granted access
// R19 - unmapped reads zero, unmapped writes dropped
// R20 - usb/lcd master refused from dual ram
// R21 - contended single blocks served in turn
module omd_decoder
(
  input  logic        clock,           // cpu clock, 40 MHz
  input  logic        resetn,          // hardware reset, async, low
  input  logic        soft_reset,      // software reset instruction pulse
  input  logic        rom_unmap_wr,    // status bit write strobe
  input  logic        rom_unmap_wdata, // status bit write value
  output logic        rom_unmap_select,// rom removed from map
  input  logic        pb_req,          // program bus read request
  input  logic [23:0] pb_addr,         // program bus byte address
  output logic        pb_gnt,          // program request taken
  output logic        pb_rvalid,       // program read data valid
  output logic [15:0] pb_rdata,        // program read data
  input  logic        db_req,          // data bus request
  input  logic        db_we,           // data bus write
  input  logic [23:0] db_addr,         // data bus byte address
  input  logic [15:0] db_wdata,        // data bus write data
  output logic        db_gnt,          // data request taken
  output logic        db_rvalid,       // data read data valid
  output logic [15:0] db_rdata,        // data read data
  input  logic        dma_req,         // dma request
  input  logic        dma_we,          // dma write
  input  logic [31:0] dma_addr,        // dma byte address
  input  logic [31:0] dma_wdata,       // dma write data
  output logic        dma_gnt,         // dma request taken
  output logic        dma_rvalid,      // dma read data valid
  output logic [31:0] dma_rdata,       // dma read data
  input  logic        usb_req,         // usb/lcd dma request
  input  logic        usb_we,          // usb/lcd dma write
  input  logic [31:0] usb_addr,        // usb/lcd dma byte address
  input  logic [31:0] usb_wdata,       // usb/lcd dma write data
  output logic        usb_gnt,         // usb/lcd request taken
  output logic        usb_rvalid,      // usb/lcd read data valid
  output logic [31:0] usb_rdata        // usb/lcd read data
);
  import omd_pkg::*;

  omd_state_s  st;
  omd_state_s  next_st;

  logic [3:0]  req;
  logic [3:0]  we;
  logic [3:0]  gnt;
  logic [3:0]  port_sel;
  logic [31:0] addr      [NUM_MASTERS];
  logic [31:0] wdata32   [NUM_MASTERS];
  logic [1:0]  wmask     [NUM_MASTERS];
  omd_dec_s    dec       [NUM_MASTERS];
  logic [31:0] rword     [NUM_MASTERS];

  logic        pa_en     [NUM_TGT];
  logic        pa_we     [NUM_TGT];
  logic [1:0]  pa_mask   [NUM_TGT];
  logic [12:0] pa_addr   [NUM_TGT];
  logic [31:0] pa_wdata  [NUM_TGT];
  logic [31:0] pa_rd     [NUM_TGT];
  logic        pb_en     [NUM_TGT];
  logic        pb_we     [NUM_TGT];
  logic [1:0]  pb_mask   [NUM_TGT];
  logic [12:0] pb_addr_w [NUM_TGT];
  logic [31:0] pb_wdata  [NUM_TGT];
  logic [31:0] pb_rd     [NUM_TGT];

  // maps a master's byte address to region, block and 32-bit word
  function automatic omd_dec_s omd_decode(input logic [1:0]  kind,
                                          input logic [31:0] a,
                                          input logic        unmap);
    omd_dec_s    d;
    logic [31:0] off;
    d.region = OMD_RG_NONE;
    d.tgt    = 6'h00;
    d.word   = 13'h0000;
    off      = 32'h0000_0000;
    if (kind == M_PB || kind == M_DB) begin
      if (a >= DUAL_CPU_BASE + MMR_BYTES && a <= DUAL_CPU_LAST) begin
        d.region = OMD_RG_DUAL;
        d.tgt    = {3'h0, a[15:13]};
        d.word   = {2'h0, a[12:2]};
      end else if (a >= SINGLE_CPU_BASE && a <= SINGLE_CPU_LAST) begin
        off      = a - SINGLE_CPU_BASE;
        d.region = OMD_RG_SINGLE;
        d.tgt    = 6'(TGT_SINGLE0) + {1'b0, off[17:13]};
        d.word   = {2'h0, off[12:2]};
      end else if (a >= ROM_BASE && a <= ROM_LAST && !unmap) begin
        off      = a - ROM_BASE;
        d.region = OMD_RG_ROM;
        d.tgt    = 6'(TGT_ROM0) + {4'h0, off[16:15]};
        d.word   = off[14:2];
      end
    end else begin
      if (kind == M_DMA &&
          a >= DUAL_CPU_BASE + DUAL_DMA_OFFSET + MMR_BYTES &&
          a <= DUAL_CPU_LAST + DUAL_DMA_OFFSET) begin
        off      = a - DUAL_DMA_OFFSET;
        d.region = OMD_RG_DUAL;
        d.tgt    = {3'h0, off[15:13]};
        d.word   = {2'h0, off[12:2]};
      end else if (a >= SINGLE_CPU_BASE + SINGLE_DMA_OFFSET &&
                   a <= SINGLE_CPU_LAST + SINGLE_DMA_OFFSET) begin
        off      = a - SINGLE_CPU_BASE - SINGLE_DMA_OFFSET;
        d.region = OMD_RG_SINGLE;
        d.tgt    = 6'(TGT_SINGLE0) + {1'b0, off[17:13]};
        d.word   = {2'h0, off[12:2]};
      end
    end
    return d;
  endfunction

  // picks the registered word a read response points at
  function automatic logic [31:0] pick_word(input omd_rsp_s r,
                                            input logic [31:0] a_rd,
                                            input logic [31:0] b_rd);
    if (!r.valid || r.region == OMD_RG_NONE) begin
      return 32'h0000_0000;                                    // see R19
    end else if (r.port) begin
      return b_rd;
    end else begin
      return a_rd;
    end
  endfunction

  // 16-bit cpu lanes sit in the word half chosen by address bit 1
  function automatic logic [1:0] cpu_lane(input logic [23:0] a);
    return a[1] ? 2'h2 : 2'h1;
  endfunction

  assign req = {usb_req, dma_req, db_req, pb_req};
  assign we  = {usb_we, dma_we, db_we, 1'b0};                  // see R15

  always_comb begin
    addr[M_PB]     = {8'h00, pb_addr};                         // see R17
    addr[M_DB]     = {8'h00, db_addr};                         // see R17
    addr[M_DMA]    = dma_addr;
    addr[M_USB]    = usb_addr;
    wdata32[M_PB]  = 32'h0000_0000;
    wdata32[M_DB]  = {db_wdata, db_wdata};
    wdata32[M_DMA] = dma_wdata;                                // see R18
    wdata32[M_USB] = usb_wdata;
    wmask[M_PB]    = 2'h0;
    wmask[M_DB]    = cpu_lane(db_addr);
    wmask[M_DMA]   = 2'h3;                                     // see R18
    wmask[M_USB]   = 2'h3;
    for (int m = 0; m < NUM_MASTERS; m++) begin
      // see R1 R4 R5 R6 R9 R11 R12 R20
      dec[m] = omd_decode(2'(m), addr[m], st.rom_unmap);
    end
  end

  // rotating priority: each master is first in line one cycle in four
  always_comb begin
    logic [1:0] used [NUM_TGT];
    logic [1:0] cap;
    logic [1:0] m;
    for (int t = 0; t < NUM_TGT; t++) begin
      used[t] = 2'h0;
    end
    cap      = 2'h0;
    m        = 2'h0;
    gnt      = 4'h0;
    port_sel = 4'h0;
    for (int i = 0; i < NUM_MASTERS; i++) begin
      m = st.rr + 2'(i);                                       // see R21
      if (req[m]) begin
        if (dec[m].region == OMD_RG_DUAL) begin
          cap = DUAL_PORTS;                                    // see R2
        end else begin
          cap = SINGLE_PORTS;                                  // see R7 R16
        end
        if (dec[m].region == OMD_RG_NONE) begin
          gnt[m] = 1'b1;                                       // see R19
        end else if (used[dec[m].tgt] < cap) begin
          gnt[m]      = 1'b1;                                  // see R21
          port_sel[m] = used[dec[m].tgt][0];
          used[dec[m].tgt] = used[dec[m].tgt] + 2'h1;
        end
      end
    end
  end

  // steer each granted master onto its block's port a or b
  always_comb begin
    logic [5:0] t;
    t = 6'h00;
    for (int k = 0; k < NUM_TGT; k++) begin
      pa_en[k]     = 1'b0;
      pa_we[k]     = 1'b0;
      pa_mask[k]   = 2'h0;
      pa_addr[k]   = 13'h0000;
      pa_wdata[k]  = 32'h0000_0000;
      pb_en[k]     = 1'b0;
      pb_we[k]     = 1'b0;
      pb_mask[k]   = 2'h0;
      pb_addr_w[k] = 13'h0000;
      pb_wdata[k]  = 32'h0000_0000;
    end
    for (int m = 0; m < NUM_MASTERS; m++) begin
      t = dec[m].tgt;
      if (req[m] && gnt[m] && dec[m].region != OMD_RG_NONE) begin
        if (!port_sel[m]) begin
          pa_en[t]    = 1'b1;                                  // see R3 R8
          pa_we[t]    = we[m] && dec[m].region != OMD_RG_ROM;  // see R19
          pa_mask[t]  = wmask[m];
          pa_addr[t]  = dec[m].word;
          pa_wdata[t] = wdata32[m];
        end else begin
          pb_en[t]     = 1'b1;                                 // see R2
          pb_we[t]     = we[m];
          pb_mask[t]   = wmask[m];
          pb_addr_w[t] = dec[m].word;
          pb_wdata[t]  = wdata32[m];
        end
      end
    end
  end

  always_comb begin
    next_st = st;
    if (rom_unmap_wr) begin
      next_st.rom_unmap = rom_unmap_wdata;                     // see R12
    end
    if (soft_reset) begin
      next_st.rom_unmap = next_st.rom_unmap;                   // see R14
    end
    next_st.rr = st.rr + 2'h1;                                 // see R21
    for (int m = 0; m < NUM_MASTERS; m++) begin
      next_st.rsp[m].valid  = req[m] && gnt[m] && !we[m];
      next_st.rsp[m].region = dec[m].region;
      next_st.rsp[m].tgt    = dec[m].tgt;
      next_st.rsp[m].port   = port_sel[m];
      next_st.rsp[m].half   = addr[m][1];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st <= OMD_STATE_RESET;                                   // see R13
    end else begin
      st <= next_st;
    end
  end

  for (genvar g = 0; g < NUM_TGT; g++) begin : g_blk
    if (g < TGT_ROM0) begin : g_ram
      omd_ram u_ram (
        .clock   (clock),
        .resetn  (resetn),
        .a_en    (pa_en[g]),
        .a_we    (pa_we[g]),
        .a_mask  (pa_mask[g]),
        .a_addr  (pa_addr[g][RAM_AW-1:0]),
        .a_wdata (pa_wdata[g]),
        .a_rdata (pa_rd[g]),
        .b_en    (pb_en[g]),
        .b_we    (pb_we[g]),
        .b_mask  (pb_mask[g]),
        .b_addr  (pb_addr_w[g][RAM_AW-1:0]),
        .b_wdata (pb_wdata[g]),
        .b_rdata (pb_rd[g])
      );
    end else begin : g_rom
      omd_rom #(
        .BLOCK (2'(g - TGT_ROM0))
      ) u_rom (
        .clock  (clock),
        .resetn (resetn),
        .en     (pa_en[g]),                                    // see R16
        .addr   (pa_addr[g]),
        .rdata  (pa_rd[g])
      );
      assign pb_rd[g] = 32'h0000_0000;
    end
  end

  always_comb begin
    for (int m = 0; m < NUM_MASTERS; m++) begin
      rword[m] = pick_word(st.rsp[m], pa_rd[st.rsp[m].tgt],
                           pb_rd[st.rsp[m].tgt]);
    end
  end

  assign rom_unmap_select = st.rom_unmap;
  assign pb_gnt     = gnt[M_PB];
  assign db_gnt     = gnt[M_DB];
  assign dma_gnt    = gnt[M_DMA];
  assign usb_gnt    = gnt[M_USB];
  assign pb_rvalid  = st.rsp[M_PB].valid;
  assign db_rvalid  = st.rsp[M_DB].valid;
  assign dma_rvalid = st.rsp[M_DMA].valid;
  assign usb_rvalid = st.rsp[M_USB].valid;
  assign pb_rdata   = st.rsp[M_PB].half ? rword[M_PB][31:16]
                                        : rword[M_PB][15:0];
  assign db_rdata   = st.rsp[M_DB].half ? rword[M_DB][31:16]
                                        : rword[M_DB][15:0];
  assign dma_rdata  = rword[M_DMA];                            // see R18
  assign usb_rdata  = rword[M_USB];

endmodule

// File: omd_pkg.sv
package omd_pkg;

  // master slots, in the order used by the arbiter
  localparam int NUM_MASTERS = 4;
  localparam logic [1:0] M_PB  = 2'h0;
  localparam logic [1:0] M_DB  = 2'h1;
  localparam logic [1:0] M_DMA = 2'h2;
  localparam logic [1:0] M_USB = 2'h3;

  // byte address map
  localparam logic [31:0] MMR_BYTES          = 32'h0000_00C0;
  localparam logic [31:0] DUAL_CPU_BASE      = 32'h0000_0000;
  localparam logic [31:0] DUAL_CPU_LAST      = 32'h0000_FFFF;
  localparam logic [31:0] DUAL_DMA_OFFSET    = 32'h0001_0000;
  localparam logic [31:0] SINGLE_CPU_BASE    = 32'h0001_0000;
  localparam logic [31:0] SINGLE_CPU_LAST    = 32'h0004_FFFF;
  localparam logic [31:0] SINGLE_DMA_OFFSET  = 32'h0008_0000;
  localparam logic [31:0] ROM_BASE           = 32'h00FE_0000;
  localparam logic [31:0] ROM_LAST           = 32'h00FF_FFFF;

  // block counts and target numbering
  localparam int NUM_DUAL    = 8;
  localparam int NUM_SINGLE  = 32;
  localparam int NUM_ROM     = 4;
  localparam int NUM_TGT     = NUM_DUAL + NUM_SINGLE + NUM_ROM;
  localparam int TGT_SINGLE0 = NUM_DUAL;
  localparam int TGT_ROM0    = NUM_DUAL + NUM_SINGLE;
  localparam int RAM_DEPTH   = 2048;
  localparam int RAM_AW      = 11;
  localparam int ROM_AW      = 13;
  localparam logic [1:0] DUAL_PORTS   = 2'h2;
  localparam logic [1:0] SINGLE_PORTS = 2'h1;

  // reset values
  localparam logic ROM_UNMAP_RESET = 1'b0;

  typedef enum logic [3:0] {
    OMD_RG_NONE   = 4'h1,
    OMD_RG_DUAL   = 4'h2,
    OMD_RG_SINGLE = 4'h4,
    OMD_RG_ROM    = 4'h8
  } omd_region_e;

  typedef struct packed {
    omd_region_e region;
    logic [5:0]  tgt;
    logic [12:0] word;
  } omd_dec_s;

  typedef struct packed {
    logic        valid;
    omd_region_e region;
    logic [5:0]  tgt;
    logic        port;
    logic        half;
  } omd_rsp_s;

  typedef struct packed {
    logic                  rom_unmap;
    logic [1:0]            rr;
    omd_rsp_s [3:0]        rsp;
  } omd_state_s;

  localparam omd_state_s OMD_STATE_RESET = '{
    rom_unmap: ROM_UNMAP_RESET,
    rr:        2'h0,
    rsp:       '0
  };

endpackage

// File: omd_ram.sv
`timescale 1ns/1ps
module omd_ram
(
  input  logic                         clock,   // cpu clock
  input  logic                         resetn,  // async reset, low
  input  logic                         a_en,    // port a access
  input  logic                         a_we,    // port a write
  input  logic [1:0]                   a_mask,  // port a halfword lanes
  input  logic [omd_pkg::RAM_AW-1:0]   a_addr,  // port a word index
  input  logic [31:0]                  a_wdata, // port a write data
  output logic [31:0]                  a_rdata, // port a read data
  input  logic                         b_en,    // port b access
  input  logic                         b_we,    // port b write
  input  logic [1:0]                   b_mask,  // port b halfword lanes
  input  logic [omd_pkg::RAM_AW-1:0]   b_addr,  // port b word index
  input  logic [31:0]                  b_wdata, // port b write data
  output logic [31:0]                  b_rdata  // port b read data
);
  import omd_pkg::*;

  logic [31:0] mem [RAM_DEPTH];

  // port b lands after port a on a same-word write collision
  always_ff @(posedge clock) begin
    if (a_en && a_we && a_mask[0]) mem[a_addr][15:0]  <= a_wdata[15:0];
    if (a_en && a_we && a_mask[1]) mem[a_addr][31:16] <= a_wdata[31:16];
    if (b_en && b_we && b_mask[0]) mem[b_addr][15:0]  <= b_wdata[15:0];
    if (b_en && b_we && b_mask[1]) mem[b_addr][31:16] <= b_wdata[31:16];
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      a_rdata <= 32'h0000_0000;
      b_rdata <= 32'h0000_0000;
    end else begin
      if (a_en && !a_we) a_rdata <= mem[a_addr];
      if (b_en && !b_we) b_rdata <= mem[b_addr];
    end
  end

endmodule

// File: omd_rom.sv
`timescale 1ns/1ps
module omd_rom
#(
  parameter logic [1:0]  BLOCK    = 2'h0,    // block number
  parameter logic [15:0] ROM_SEED = 16'hA5C3 // arbitrary content pattern
)
(
  input  logic                       clock,  // cpu clock
  input  logic                       resetn, // async reset, low
  input  logic                       en,     // read this cycle
  input  logic [omd_pkg::ROM_AW-1:0] addr,   // word index
  output logic [31:0]                rdata   // registered word
);
  import omd_pkg::*;

  // stand-in contents until the boot image is fixed in silicon
  function automatic logic [15:0] rom_half(input logic [ROM_AW-1:0] a,
                                           input logic              hi);
    return {BLOCK, a, hi} ^ ROM_SEED;
  endfunction

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata <= 32'h0000_0000;
    end else if (en) begin
      rdata <= {rom_half(addr, 1'b1), rom_half(addr, 1'b0)};
    end
  end

endmodule

// File: omd_decoder_sva.sv
`timescale 1ns/1ps
module omd_decoder_sva
(
  input logic        clock,            // cpu clock
  input logic        resetn,           // async reset, low
  input logic        rom_unmap_wr,     // unmap bit write
  input logic        rom_unmap_wdata,  // unmap bit value
  input logic        rom_unmap_select, // unmap bit
  input logic        pb_req,           // program request
  input logic [23:0] pb_addr,          // program address
  input logic        pb_gnt,           // program taken
  input logic        pb_rvalid,        // program answer
  input logic [15:0] pb_rdata,         // program data
  input logic        db_req,           // data request
  input logic        db_we,            // data write
  input logic        db_gnt,           // data taken
  input logic        db_rvalid,        // data answer
  input logic        dma_req,          // dma request
  input logic        dma_we,           // dma write
  input logic        dma_gnt,          // dma taken
  input logic        dma_rvalid,       // dma answer
  input logic        usb_req,          // usb request
  input logic        usb_we,           // usb write
  input logic [31:0] usb_addr,         // usb address
  input logic        usb_gnt,          // usb taken
  input logic        usb_rvalid,       // usb answer
  input logic [31:0] usb_rdata         // usb data
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  pb_answer_a: assert property (pb_req && pb_gnt |=> pb_rvalid)
    else $error("program read not answered next cycle");
  pb_no_ghost_a: assert property (!(pb_req && pb_gnt) |=> !pb_rvalid)
    else $error("program answer without a taken request");
  db_write_quiet_a: assert property (db_req && db_gnt && db_we |=> !db_rvalid)
    else $error("data write produced an answer");
  dma_answer_a: assert property (dma_req && dma_gnt && !dma_we |=> dma_rvalid)
    else $error("dma read not answered next cycle");
  usb_dual_zero_a: assert property (usb_req && usb_gnt && !usb_we &&
    usb_addr[31:16] == 16'h0001 |=> usb_rvalid && usb_rdata == 32'h0)
    else $error("usb reached dual ram");
  rom_gone_zero_a: assert property (pb_req && pb_gnt && rom_unmap_select &&
    pb_addr[23:17] == 7'h7F |=> pb_rdata == 16'h0)
    else $error("unmapped rom range returned data");
  unmap_write_a: assert property (rom_unmap_wr |=>
    rom_unmap_select == $past(rom_unmap_wdata))
    else $error("unmap bit not written");
  unmap_hold_a: assert property (!rom_unmap_wr |=> $stable(rom_unmap_select))
    else $error("unmap bit changed without a write");
  unmap_reset_a: assert property ($rose(resetn) |-> !rom_unmap_select)
    else $error("unmap bit set after reset");
  dma_stall_a: assert property (dma_req |-> ##[0:4] dma_gnt)
    else $error("dma request starved");
  usb_stall_a: assert property (usb_req |-> ##[0:4] usb_gnt)
    else $error("usb request starved");

  cover property (db_req && db_gnt && dma_req && dma_gnt);
  cover property (dma_req && !dma_gnt);
  cover property (rom_unmap_select && pb_req && pb_gnt);
endmodule

bind omd_decoder omd_decoder_sva chk_i (.clock, .resetn, .rom_unmap_wr,
  .rom_unmap_wdata, .rom_unmap_select, .pb_req, .pb_addr, .pb_gnt,
  .pb_rvalid, .pb_rdata, .db_req, .db_we, .db_gnt, .db_rvalid, .dma_req,
  .dma_we, .dma_gnt, .dma_rvalid, .usb_req, .usb_we, .usb_addr, .usb_gnt,
  .usb_rvalid, .usb_rdata);

// File: omd_master_bfm.sv
`timescale 1ns/1ps
module omd_master_bfm
#(
  parameter int AW = 32, // address width
  parameter int DW = 32  // data width
)
(
  input  logic          clock,  // cpu clock
  output logic          req,    // request
  output logic          we,     // write
  output logic [AW-1:0] addr,   // byte address
  output logic [DW-1:0] wdata,  // write data
  input  logic          gnt,    // taken
  input  logic          rvalid, // answer
  input  logic [DW-1:0] rdata   // answer data
);
  initial begin
    req   = 1'b0;
    we    = 1'b0;
    addr  = '0;
    wdata = '0;
  end

  // callers keep clear of the boot block while booting
  task automatic xfer(input logic w, input logic [AW-1:0] a,
                      input logic [DW-1:0] d,
                      output logic [DW-1:0] q, output logic v);
    logic g;
    g = 1'b0;
    @(negedge clock);
    req   = 1'b1;
    we    = w;
    addr  = a;
    wdata = d;
    for (int i = 0; i < 8 && !g; i++) begin
      #10;
      g = gnt;
      @(posedge clock);
    end
    @(negedge clock);
    q     = rdata;
    v     = rvalid;
    req   = 1'b0;
    // released lines flip so stale values never look live
    addr  = ~a;
    wdata = ~d;
  endtask
endmodule

// File: onchip_memory_map_decoder_bench.sv
`timescale 1ns/1ps
module onchip_memory_map_decoder_bench;
  import omd_pkg::*;
  logic        clock, resetn, soft_reset, rom_unmap_wr, rom_unmap_wdata;
  logic        rom_unmap_select, pb_req, pb_gnt, pb_rvalid;
  logic        db_req, db_we, db_gnt, db_rvalid;
  logic        dma_req, dma_we, dma_gnt, dma_rvalid;
  logic        usb_req, usb_we, usb_gnt, usb_rvalid;
  logic [23:0] pb_addr, db_addr;
  logic [15:0] pb_rdata, db_wdata, db_rdata;
  logic [31:0] dma_addr, dma_wdata, dma_rdata;
  logic [31:0] usb_addr, usb_wdata, usb_rdata;
  int          bad_count = 0;
  int          cmp_count = 0;

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  omd_decoder DUT (.clock, .resetn, .soft_reset, .rom_unmap_wr,
    .rom_unmap_wdata, .rom_unmap_select, .pb_req, .pb_addr, .pb_gnt,
    .pb_rvalid, .pb_rdata, .db_req, .db_we, .db_addr, .db_wdata, .db_gnt,
    .db_rvalid, .db_rdata, .dma_req, .dma_we, .dma_addr, .dma_wdata,
    .dma_gnt, .dma_rvalid, .dma_rdata, .usb_req, .usb_we, .usb_addr,
    .usb_wdata, .usb_gnt, .usb_rvalid, .usb_rdata);

  omd_master_bfm #(.AW(24), .DW(16)) pbm (.clock, .req(pb_req), .we(),
    .addr(pb_addr), .wdata(), .gnt(pb_gnt), .rvalid(pb_rvalid),
    .rdata(pb_rdata));
  omd_master_bfm #(.AW(24), .DW(16)) dbm (.clock, .req(db_req),
    .we(db_we), .addr(db_addr), .wdata(db_wdata), .gnt(db_gnt),
    .rvalid(db_rvalid), .rdata(db_rdata));
  omd_master_bfm dmam (.clock, .req(dma_req), .we(dma_we),
    .addr(dma_addr), .wdata(dma_wdata), .gnt(dma_gnt),
    .rvalid(dma_rvalid), .rdata(dma_rdata));
  omd_master_bfm usbm (.clock, .req(usb_req), .we(usb_we),
    .addr(usb_addr), .wdata(usb_wdata), .gnt(usb_gnt),
    .rvalid(usb_rvalid), .rdata(usb_rdata));

  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic acc(input logic [1:0] m, input logic w,
                     input logic [31:0] a, input logic [31:0] d,
                     input logic [31:0] e);
    logic [15:0] q16;
    logic [31:0] q;
    logic        v;
    q16 = '0;
    q   = '0;
    case (m)
      M_PB: pbm.xfer(w, a[23:0], d[15:0], q16, v);
      M_DB: dbm.xfer(w, a[23:0], d[15:0], q16, v);
      M_DMA: dmam.xfer(w, a, d, q, v);
      default: usbm.xfer(w, a, d, q, v);
    endcase
    if (m == M_PB || m == M_DB) q = {16'h0, q16};
    chk("rvalid", {31'h0, v}, {31'h0, !w});
    if (!w) chk("rdata", q, e);
  endtask

  function automatic logic [31:0] rom_half(input logic [1:0] b,
                                           input logic [12:0] w,
                                           input logic h);
    return {16'h0, {b, w, h} ^ 16'hA5C3};
  endfunction

  task automatic do_reset;
    resetn = 1'b0;
    repeat (10) @(negedge clock);
    resetn = 1'b1;
  endtask

  task automatic t_dual;
    acc(M_DMA, 1, 32'h000100C0, 32'hCAFE1234, 0);
    acc(M_PB, 0, 32'h0000C0, 0, 32'h1234);
    acc(M_DB, 0, 32'h0000C2, 0, 32'hCAFE);
    acc(M_DB, 1, 32'h00FFFE, 32'hBEEF, 0);
    acc(M_DB, 1, 32'h00FFFC, 32'h0001, 0);
    acc(M_DMA, 0, 32'h0001FFFC, 0, 32'hBEEF0001);
    acc(M_DB, 1, 32'h000000, 32'h5555, 0);
    acc(M_DB, 0, 32'h000000, 0, 0);
    fork
      acc(M_DB, 1, 32'h002000, 32'h1111, 0);
      acc(M_DMA, 1, 32'h00012004, 32'h22223333, 0);
    join
    fork
      acc(M_PB, 0, 32'h002000, 0, 32'h1111);
      acc(M_DMA, 0, 32'h00012004, 0, 32'h22223333);
    join
  endtask

  task automatic t_single;
    acc(M_DMA, 1, 32'h00090000, 32'hA1B2C3D4, 0);
    acc(M_PB, 0, 32'h010000, 0, 32'hC3D4);
    acc(M_DB, 0, 32'h010002, 0, 32'hA1B2);
    acc(M_USB, 1, 32'h000CFFFC, 32'h0F0E0D0C, 0);
    acc(M_DB, 0, 32'h04FFFE, 0, 32'h0F0E);
    acc(M_USB, 0, 32'h000CFFFC, 0, 32'h0F0E0D0C);
    acc(M_USB, 1, 32'h000100C0, 32'hFFFFFFFF, 0);
    acc(M_DMA, 0, 32'h000100C0, 0, 32'hCAFE1234);
    acc(M_USB, 0, 32'h00010100, 0, 0);
    fork
      acc(M_DMA, 1, 32'h00092000, 32'h11112222, 0);
      acc(M_USB, 1, 32'h00092004, 32'h33334444, 0);
      acc(M_DB, 1, 32'h012008, 32'h5555, 0);
    join
    fork
      acc(M_DMA, 0, 32'h00092004, 0, 32'h33334444);
      acc(M_USB, 0, 32'h00092000, 0, 32'h11112222);
      acc(M_PB, 0, 32'h012008, 0, 32'h5555);
    join
  endtask

  task automatic t_rom;
    for (int b = 0; b < 4; b++) begin
      acc(M_PB, 0, {8'h0, 7'h7F, b[1:0], 15'h0}, 0,
          rom_half(b[1:0], 13'h0, 1'b0));
      acc(M_DB, 0, {8'h0, 7'h7F, b[1:0], 15'h6}, 0,
          rom_half(b[1:0], 13'h1, 1'b1));
    end
    acc(M_PB, 0, 32'hFFFFFE, 0, rom_half(2'h3, 13'h1FFF, 1'b1));
    acc(M_DMA, 0, 32'h00FE0000, 0, 0);
    acc(M_PB, 0, 32'h500000, 0, 0);
    acc(M_DB, 1, 32'h500000, 32'h7777, 0);
    acc(M_DB, 0, 32'h500000, 0, 0);
  endtask

  task automatic t_unmap;
    @(negedge clock);
    rom_unmap_wr    = 1'b1;
    rom_unmap_wdata = 1'b1;
    @(negedge clock);
    rom_unmap_wr    = 1'b0;
    chk("unmap", {31'h0, rom_unmap_select}, 32'h1);
    acc(M_PB, 0, 32'hFE0000, 0, 0);
    soft_reset = 1'b1;
    @(negedge clock);
    soft_reset = 1'b0;
    @(negedge clock);
    chk("unmap", {31'h0, rom_unmap_select}, 32'h1);
    acc(M_DB, 0, 32'hFE0002, 0, 0);
    do_reset;
    chk("unmap", {31'h0, rom_unmap_select}, 32'h0);
    acc(M_PB, 0, 32'hFE0000, 0, rom_half(2'h0, 13'h0, 1'b0));
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #100000;
    bad_count++;
    end_sim;
  end

  initial begin
    soft_reset      = 1'b0;
    rom_unmap_wr    = 1'b0;
    rom_unmap_wdata = 1'b0;
    do_reset;
    t_dual;
    t_single;
    t_rom;
    t_unmap;
    end_sim;
  end
endmodule
